// file: hw/tst_device.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
module tst_device #(
	parameter int P_TICK_CYCLES = tst_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// link to the controller
	tst_link_if.dev lk,
	// user side
	output tst_pkg::tst_time_s o_time,
	output logic o_leader,
	output logic o_busy
);

	// --------------------------------------------------------------
	// types and state
	// --------------------------------------------------------------
	localparam int PW = $clog2(P_TICK_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(P_TICK_CYCLES - 1);

	typedef enum logic [2:0] {
		S_IDLE,
		S_RECV,
		S_APPLY,
		S_SEND,
		S_DONE
	} tst_dev_st_e;

	typedef struct packed {
		tst_dev_st_e st;
		logic leader;
		logic [3:0] len;
		logic [3:0] cnt;
		logic bad;
		logic [9:0][7:0] wbuf;
		logic [9:0][7:0] snap;
		logic [PW-1:0] pre;
		logic tick;
		logic load;
		tst_pkg::tst_time_s ltime;
		logic rd_stb;
		logic [7:0] rd_data;
		logic done;
		logic err;
	} tst_dev_s;

	tst_dev_s st_ff;
	tst_dev_s nxt_st;
	tst_pkg::tst_time_s cur_time;

	// --------------------------------------------------------------
	// timekeeping
	// --------------------------------------------------------------
	tst_bcd_clock u_clock (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_tick(st_ff.tick),
		.i_load(st_ff.load),
		.i_time(st_ff.ltime),
		.o_time(cur_time)
	);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rd_stb = 1'b0;
		nxt_st.done = 1'b0;
		nxt_st.load = 1'b0;
		nxt_st.tick = 1'b0;

		// hundredths prescaler
		if (st_ff.pre == PRE_LAST)
		begin
			nxt_st.pre = '0;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.pre = st_ff.pre + 1'b1;

		// sync realigns the prescaler only; leader is left alone
		if (lk.sync_stb)
			nxt_st.pre = '0;

		// keep the answer built in advance so a read starts at once;
		// frozen while a job runs so the ten bytes are coherent
		if (st_ff.leader && st_ff.st == S_IDLE)
		begin
			nxt_st.snap[tst_pkg::OFS_LEADER] = {7'h00, st_ff.leader};
			nxt_st.snap[tst_pkg::OFS_SPARE] = 8'h00;
			nxt_st.snap[tst_pkg::OFS_FRAC] = cur_time.frac;
			nxt_st.snap[tst_pkg::OFS_SEC] = cur_time.sec;
			nxt_st.snap[tst_pkg::OFS_MIN] = cur_time.min;
			nxt_st.snap[tst_pkg::OFS_HOUR] = cur_time.hour;
			nxt_st.snap[tst_pkg::OFS_DAY] = cur_time.day;
			nxt_st.snap[tst_pkg::OFS_MONTH] = cur_time.month;
			nxt_st.snap[tst_pkg::OFS_YEAR] = cur_time.year;
			nxt_st.snap[tst_pkg::OFS_ZERO] = 8'h00;
		end

		case (st_ff.st)
			S_IDLE:
			begin
				if (lk.job_stb)
				begin
					nxt_st.cnt = 4'h0;
					nxt_st.len = lk.job_len;
					nxt_st.bad = (lk.job_num != tst_pkg::JOB_TIME);
					if (lk.job_wr)
					begin
						// only the flag alone or the whole area is accepted
						if (lk.job_len != tst_pkg::LEN_FULL &&
							lk.job_len != tst_pkg::LEN_FLAG)
							nxt_st.bad = 1'b1;
						nxt_st.st = (lk.job_len == 4'h0) ? S_DONE : S_RECV;
					end
					else if (!st_ff.leader || nxt_st.bad)
					begin
						nxt_st.bad = 1'b1;
						nxt_st.st = S_DONE;
					end
					else
						nxt_st.st = S_SEND;
				end
			end
			S_RECV:
			begin
				if (lk.wr_stb)
				begin
					// excess bytes of a bad job are swallowed, not stored
					if (st_ff.cnt <= tst_pkg::LAST_IDX)
						nxt_st.wbuf[st_ff.cnt] = lk.wr_data;
					nxt_st.cnt = st_ff.cnt + 4'h1;
					if (st_ff.cnt + 4'h1 == st_ff.len)
						nxt_st.st = S_APPLY;
				end
			end
			S_APPLY:
			begin
				if (!st_ff.bad)
				begin
					// flag comes from the write every time, so a leader
					// that is not told again becomes a follower
					nxt_st.leader =
						st_ff.wbuf[tst_pkg::OFS_LEADER][tst_pkg::LEADER_BIT];
					if (st_ff.len == tst_pkg::LEN_FULL)
					begin
						nxt_st.load = 1'b1;
						nxt_st.pre = '0;
						nxt_st.ltime.frac = st_ff.wbuf[tst_pkg::OFS_FRAC];
						nxt_st.ltime.sec = st_ff.wbuf[tst_pkg::OFS_SEC];
						nxt_st.ltime.min = st_ff.wbuf[tst_pkg::OFS_MIN];
						nxt_st.ltime.hour = st_ff.wbuf[tst_pkg::OFS_HOUR];
						nxt_st.ltime.day = st_ff.wbuf[tst_pkg::OFS_DAY];
						nxt_st.ltime.month = st_ff.wbuf[tst_pkg::OFS_MONTH];
						nxt_st.ltime.year = st_ff.wbuf[tst_pkg::OFS_YEAR];
					end
				end
				nxt_st.st = S_DONE;
			end
			S_SEND:
			begin
				nxt_st.rd_stb = 1'b1;
				nxt_st.rd_data = st_ff.snap[st_ff.cnt];
				nxt_st.cnt = st_ff.cnt + 4'h1;
				if (st_ff.cnt == tst_pkg::LAST_IDX)
					nxt_st.st = S_DONE;
			end
			S_DONE:
			begin
				nxt_st.done = 1'b1;
				nxt_st.err = st_ff.bad;
				nxt_st.st = S_IDLE;
			end
			default:
				nxt_st.st = S_IDLE;
		endcase
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	// reset is the cold restart: follower, counting from the default
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_ff <= '0;
			st_ff.st <= S_IDLE;
			st_ff.leader <= 1'b0;
		end
		else
			st_ff <= nxt_st;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign lk.rd_stb = st_ff.rd_stb;
	assign lk.rd_data = st_ff.rd_data;
	assign lk.done_stb = st_ff.done;
	assign lk.done_err = st_ff.err;
	assign o_time = cur_time;
	assign o_leader = st_ff.leader;
	assign o_busy = (st_ff.st != S_IDLE);

endmodule

// file: hw/tst_pkg.sv
package tst_pkg;

	// ---------------------------------------------------------------
	// link job codes and lengths
	// ---------------------------------------------------------------
	localparam logic [7:0] JOB_TIME = 8'hda; // job number 218
	localparam logic [3:0] LEN_FULL = 4'ha; // whole transfer area
	localparam logic [3:0] LEN_FLAG = 4'h1; // leader byte alone
	localparam logic [3:0] LAST_IDX = 4'h9; // last byte of the area

	// ---------------------------------------------------------------
	// transfer area byte offsets and fields
	// ---------------------------------------------------------------
	localparam int OFS_LEADER = 0;
	localparam int OFS_SPARE = 1;
	localparam int OFS_FRAC = 2;
	localparam int OFS_SEC = 3;
	localparam int OFS_MIN = 4;
	localparam int OFS_HOUR = 5;
	localparam int OFS_DAY = 6;
	localparam int OFS_MONTH = 7;
	localparam int OFS_YEAR = 8;
	localparam int OFS_ZERO = 9;
	localparam int LEADER_BIT = 0;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int HUNDREDTH_NS = 10_000_000;
	localparam int TICK_CYCLES = HUNDREDTH_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// calendar limits and reset values, all bcd
	// ---------------------------------------------------------------
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] FRAC_MAX = 8'h99;
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] FEB = 8'h02;
	localparam logic [7:0] DAYS_28 = 8'h28;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_31 = 8'h31;

	// ---------------------------------------------------------------
	// controller register map (apb byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_BUF0 = 8'h08;
	localparam logic [7:0] REG_BUF1 = 8'h0c;
	localparam logic [7:0] REG_BUF2 = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WR = 1;
	localparam int CTRL_SYNC = 2;
	localparam int CTRL_LEN_LSB = 4;
	localparam int CTRL_JOB_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ERR = 2;
	localparam int STAT_LEADER = 3;

	typedef struct packed {
		logic [7:0] frac;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] month;
		logic [7:0] year;
	} tst_time_s;

endpackage

// file: hw/tst_link_if.sv
`timescale 1ns/1ps
interface tst_link_if;
	logic job_stb;
	logic [7:0] job_num;
	logic job_wr;
	logic [3:0] job_len;
	logic wr_stb;
	logic [7:0] wr_data;
	logic sync_stb;
	logic rd_stb;
	logic [7:0] rd_data;
	logic done_stb;
	logic done_err;

	modport dev (
		input job_stb, job_num, job_wr, job_len, wr_stb, wr_data, sync_stb,
		output rd_stb, rd_data, done_stb, done_err
	);
	modport host (
		output job_stb, job_num, job_wr, job_len, wr_stb, wr_data, sync_stb,
		input rd_stb, rd_data, done_stb, done_err
	);
endinterface

// file: hw/tst_bcd_clock.sv
`timescale 1ns/1ps
module tst_bcd_clock (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_tick,
	input wire logic i_load,
	input wire tst_pkg::tst_time_s i_time,
	// current time
	output tst_pkg::tst_time_s o_time
);

	typedef struct packed {
		tst_pkg::tst_time_s t;
	} tst_clk_s;

	tst_clk_s st_ff;
	tst_clk_s nxt_st;

	// one bcd step, returns carry and new value
	function automatic logic [8:0] tst_step(input logic [7:0] v,
		input logic [7:0] max, input logic [7:0] low, input logic c);
		if (!c)
			tst_step = {1'b0, v};
		else if (v == max)
			tst_step = {1'b1, low};
		else if (v[3:0] == 4'h9)
			tst_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			tst_step = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	// last day of the month; year 00 counts as leap
	function automatic logic [7:0] tst_last_day(input logic [7:0] mon,
		input logic [7:0] yr);
		logic [4:0] s;
		s = {yr[7:4], 1'b0} + {1'b0, yr[3:0]};
		case (mon)
			tst_pkg::FEB: tst_last_day = (s[1:0] == 2'h0) ?
				tst_pkg::DAYS_29 : tst_pkg::DAYS_28;
			8'h04, 8'h06, 8'h09, 8'h11: tst_last_day = tst_pkg::DAYS_30;
			default: tst_last_day = tst_pkg::DAYS_31;
		endcase
	endfunction

	// --------------------------------------------------------------
	// counting chain
	// --------------------------------------------------------------
	// load has priority: a fresh time must not be bumped by a tick
	always_comb
	begin
		logic c;
		c = i_tick;
		nxt_st = st_ff;
		if (i_load)
			nxt_st.t = i_time;
		else
		begin
			{c, nxt_st.t.frac} = tst_step(st_ff.t.frac, tst_pkg::FRAC_MAX,
				tst_pkg::BCD_ZERO, c);
			{c, nxt_st.t.sec} = tst_step(st_ff.t.sec, tst_pkg::SEC_MAX,
				tst_pkg::BCD_ZERO, c);
			{c, nxt_st.t.min} = tst_step(st_ff.t.min, tst_pkg::SEC_MAX,
				tst_pkg::BCD_ZERO, c);
			{c, nxt_st.t.hour} = tst_step(st_ff.t.hour, tst_pkg::HOUR_MAX,
				tst_pkg::BCD_ZERO, c);
			{c, nxt_st.t.day} = tst_step(st_ff.t.day,
				tst_last_day(st_ff.t.month, st_ff.t.year),
				tst_pkg::BCD_ONE, c);
			{c, nxt_st.t.month} = tst_step(st_ff.t.month, tst_pkg::MONTH_MAX,
				tst_pkg::BCD_ONE, c);
			{c, nxt_st.t.year} = tst_step(st_ff.t.year, tst_pkg::YEAR_MAX,
				tst_pkg::BCD_ZERO, c);
		end
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_ff.t <= '{frac: tst_pkg::BCD_ZERO, sec: tst_pkg::BCD_ZERO,
				min: tst_pkg::BCD_ZERO, hour: tst_pkg::BCD_ZERO,
				day: tst_pkg::BCD_ONE, month: tst_pkg::BCD_ONE,
				year: tst_pkg::BCD_ZERO};
		end
		else
			st_ff <= nxt_st;
	end

	assign o_time = st_ff.t;

endmodule

// file: hw/tst_host.sv
`timescale 1ns/1ps
module tst_host (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// link to the device
	tst_link_if.host lk
);

	typedef enum logic [1:0] {
		H_IDLE,
		H_SEND,
		H_WAIT
	} tst_host_st_e;

	typedef struct packed {
		tst_host_st_e st;
		logic wr;
		logic [3:0] len;
		logic [7:0] job;
		logic [3:0] cnt;
		logic [9:0][7:0] buffer;
		logic done;
		logic err;
		logic job_stb;
		logic wr_stb;
		logic [7:0] wr_data;
		logic sync_stb;
	} tst_host_s;

	tst_host_s st_ff;
	tst_host_s nxt_st;
	logic wr_acc;
	logic hit;

	assign wr_acc = i_psel && i_penable && i_pwrite;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.job_stb = 1'b0;
		nxt_st.wr_stb = 1'b0;
		nxt_st.sync_stb = 1'b0;

		// register writes
		if (wr_acc)
		begin
			case (i_paddr)
				tst_pkg::REG_CTRL:
				begin
					nxt_st.sync_stb = i_pwdata[tst_pkg::CTRL_SYNC];
					// a new job is refused while one is running
					if (st_ff.st == H_IDLE)
					begin
						nxt_st.wr = i_pwdata[tst_pkg::CTRL_WR];
						nxt_st.len = i_pwdata[tst_pkg::CTRL_LEN_LSB +: 4];
						nxt_st.job = i_pwdata[tst_pkg::CTRL_JOB_LSB +: 8];
						if (i_pwdata[tst_pkg::CTRL_GO])
						begin
							nxt_st.job_stb = 1'b1;
							nxt_st.cnt = 4'h0;
							nxt_st.st = (i_pwdata[tst_pkg::CTRL_WR] &&
								i_pwdata[tst_pkg::CTRL_LEN_LSB +: 4] != 4'h0) ?
								H_SEND : H_WAIT;
						end
					end
				end
				tst_pkg::REG_STAT:
				begin
					if (i_pwdata[tst_pkg::STAT_DONE])
						nxt_st.done = 1'b0;
					if (i_pwdata[tst_pkg::STAT_ERR])
						nxt_st.err = 1'b0;
				end
				tst_pkg::REG_BUF0: nxt_st.buffer[3:0] = i_pwdata;
				tst_pkg::REG_BUF1: nxt_st.buffer[7:4] = i_pwdata;
				tst_pkg::REG_BUF2: nxt_st.buffer[9:8] = i_pwdata[15:0];
				default: ;
			endcase
		end

		case (st_ff.st)
			H_SEND:
			begin
				nxt_st.wr_stb = 1'b1;
				nxt_st.wr_data = (st_ff.cnt <= tst_pkg::LAST_IDX) ?
					st_ff.buffer[st_ff.cnt] : 8'h00;
				nxt_st.cnt = st_ff.cnt + 4'h1;
				if (st_ff.cnt + 4'h1 == st_ff.len)
				begin
					nxt_st.cnt = 4'h0;
					nxt_st.st = H_WAIT;
				end
			end
			H_WAIT:
			begin
				// all ten bytes land in the buffer, leader byte too
				if (lk.rd_stb && st_ff.cnt <= tst_pkg::LAST_IDX)
				begin
					nxt_st.buffer[st_ff.cnt] = lk.rd_data;
					nxt_st.cnt = st_ff.cnt + 4'h1;
				end
				// completion set wins over a same-cycle software clear
				if (lk.done_stb)
				begin
					nxt_st.done = 1'b1;
					nxt_st.err = lk.done_err;
					nxt_st.st = H_IDLE;
				end
			end
			H_IDLE: ;
			default: nxt_st.st = H_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_ff <= '0;
			st_ff.st <= H_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// --------------------------------------------------------------
	// apb read path, zero wait states
	// --------------------------------------------------------------
	always_comb
	begin
		hit = 1'b1;
		o_prdata = 32'h0000_0000;
		case (i_paddr)
			tst_pkg::REG_CTRL: o_prdata = {16'h0000, st_ff.job,
				st_ff.len, 2'h0, st_ff.wr, 1'b0};
			tst_pkg::REG_STAT: o_prdata = {28'h0000000,
				st_ff.buffer[tst_pkg::OFS_LEADER][tst_pkg::LEADER_BIT],
				st_ff.err, st_ff.done, st_ff.st != H_IDLE};
			tst_pkg::REG_BUF0: o_prdata = st_ff.buffer[3:0];
			tst_pkg::REG_BUF1: o_prdata = st_ff.buffer[7:4];
			tst_pkg::REG_BUF2: o_prdata = {16'h0000, st_ff.buffer[9:8]};
			default: hit = 1'b0;
		endcase
	end

	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;

	// link outputs
	assign lk.job_stb = st_ff.job_stb;
	assign lk.job_num = st_ff.job;
	assign lk.job_wr = st_ff.wr;
	assign lk.job_len = st_ff.len;
	assign lk.wr_stb = st_ff.wr_stb;
	assign lk.wr_data = st_ff.wr_data;
	assign lk.sync_stb = st_ff.sync_stb;

endmodule

// file: verif/tst_link_monitor.sv
`timescale 1ns/1ps
module tst_link_monitor (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// link signals, named as on the interface
	input wire logic job_stb,
	input wire logic [7:0] job_num,
	input wire logic job_wr,
	input wire logic [3:0] job_len,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic sync_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rd_data,
	input wire logic done_stb,
	input wire logic done_err
);
	// ---------------------------------------------------------------
	// leader flag as seen from the link
	// ---------------------------------------------------------------
	typedef struct packed {
		logic lead;
		logic pend;
		logic first;
		logic is_wr;
	} tst_mon_s;
	tst_mon_s mon_ff;
	tst_mon_s nxt_mon;

	// only byte 0 of a write carries the flag, so latch the first byte
	always_comb
	begin
		nxt_mon = mon_ff;
		if (job_stb)
		begin
			nxt_mon.is_wr = job_wr;
			nxt_mon.first = 1'b1;
		end
		if (wr_stb && mon_ff.first)
		begin
			nxt_mon.pend = wr_data[0];
			nxt_mon.first = 1'b0;
		end
		if (done_stb && !done_err && mon_ff.is_wr)
			nxt_mon.lead = mon_ff.pend;
		if (!i_rst_b)
			nxt_mon = '0;
	end

	// register the shadow state
	always_ff @(posedge i_clk)
	begin
		mon_ff <= nxt_mon;
	end

	// ---------------------------------------------------------------
	// link timing
	// ---------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	// ten read bytes back to back, then a clean done
	sequence rd_burst;
		rd_stb [*8] ##1 rd_stb [*2] ##1 (done_stb && !done_err && !rd_stb);
	endsequence
	sequence refused;
		done_stb && done_err && !rd_stb;
	endsequence
	sequence wr_burst;
		wr_stb [*8] ##1 wr_stb [*2] ##1 !wr_stb;
	endsequence

	read_shape_a: assert property (
		job_stb && !job_wr |-> ##2 (rd_burst or refused))
		else $error("read transfer has wrong shape");
	follower_refuse_a: assert property (
		job_stb && !job_wr && !mon_ff.lead |-> ##2 refused)
		else $error("read served while not leader");
	leader_byte_a: assert property (
		job_stb && !job_wr && mon_ff.lead && job_num == tst_pkg::JOB_TIME
		|-> ##2 rd_stb && rd_data[tst_pkg::LEADER_BIT])
		else $error("leader flag missing in byte 0");
	zero_byte_a: assert property (
		job_stb && !job_wr && mon_ff.lead && job_num == tst_pkg::JOB_TIME
		|-> ##11 rd_stb && rd_data == 8'h00)
		else $error("last byte of area not zero");
	wrong_job_a: assert property (
		job_stb && job_num != tst_pkg::JOB_TIME
		|-> ##[2:13] done_stb && done_err)
		else $error("foreign job number not refused");
	full_write_a: assert property (
		job_stb && job_wr && job_len == tst_pkg::LEN_FULL |-> ##13 done_stb)
		else $error("full write done late or early");
	flag_write_a: assert property (
		job_stb && job_wr && job_len == tst_pkg::LEN_FLAG |-> ##4 done_stb)
		else $error("flag write done late or early");
	byte_count_a: assert property (
		job_stb && job_wr && job_len == tst_pkg::LEN_FULL |=> wr_burst)
		else $error("full write not ten bytes");
	done_pulse_a: assert property (done_stb |=> !done_stb)
		else $error("done strobe longer than one cycle");
	err_hold_a: assert property (!done_stb |-> $stable(done_err))
		else $error("error level moved without done");
endmodule

// file: verif/tst_tb_top.sv
`timescale 1ns/1ps
module tst_tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic i_clk;
	logic i_rst_b;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tst_pkg::tst_time_s dev_time;
	logic dev_leader;
	logic dev_busy;
	int n_fail;
	int n_checks;
	int seed;
	int k;
	logic [31:0] q;
	logic [31:0] st;
	logic e;
	tst_pkg::tst_time_s t;
	tst_pkg::tst_time_s t2;
	// corner times and the time one hundredth later
	tst_pkg::tst_time_s cin [4] = '{56'h99595923311299, 56'h99595923280201,
		56'h99595923280204, 56'h99595923300420};
	tst_pkg::tst_time_s cout [4] = '{56'h00000000010100, 56'h00000000010301,
		56'h00000000290204, 56'h00000000010520};

	tst_link_if lk();

	tst_host i_tst_host (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.lk(lk)
	);
	// a long prescaler keeps the time still between load and read-back
	tst_device #(.P_TICK_CYCLES(1000)) i_tst_device (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.lk(lk),
		.o_time(dev_time),
		.o_leader(dev_leader),
		.o_busy(dev_busy)
	);
	tst_link_monitor i_tst_link_monitor (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.job_stb(lk.job_stb),
		.job_num(lk.job_num),
		.job_wr(lk.job_wr),
		.job_len(lk.job_len),
		.wr_stb(lk.wr_stb),
		.wr_data(lk.wr_data),
		.sync_stb(lk.sync_stb),
		.rd_stb(lk.rd_stb),
		.rd_data(lk.rd_data),
		.done_stb(lk.done_stb),
		.done_err(lk.done_err)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the run needs well under this many cycles
	initial
	begin
		#(8 * 40000);
		n_fail++;
		end_sim;
	end

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task chk_time(input tst_pkg::tst_time_s got, input tst_pkg::tst_time_s exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: time %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; the request stands until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1)
			@(posedge i_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// start a job, poll until done, then clear the sticky bits
	task job(input logic wr, input logic [7:0] num, input logic [3:0] len,
		output logic [31:0] s);
		logic [31:0] d;
		logic x;
		// go in bit 0, direction in bit 1
		apb(1'b1, tst_pkg::REG_CTRL, {16'h0000, num, len, 2'h0, wr, 1'b1},
			d, x);
		// strobe one cycle after the write, device busy the cycle after
		repeat (2) @(posedge i_clk);
		chk_word({31'h0, dev_busy}, 32'h1);
		s = '0;
		for (int i = 0; i < 60 && s[tst_pkg::STAT_DONE] !== 1'b1; i++)
			apb(1'b0, tst_pkg::REG_STAT, 32'h0, s, x);
		apb(1'b1, tst_pkg::REG_STAT, 32'h6, d, x);
	endtask

	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction

	function automatic logic [31:0] word0(input logic f,
		input tst_pkg::tst_time_s tm);
		return {tm.sec, tm.frac, 8'h00, 7'h00, f};
	endfunction

	// fill the three buffer words, then send with the given job fields
	task load(input logic f, input logic [7:0] num, input logic [3:0] len,
		input tst_pkg::tst_time_s tm, output logic [31:0] s);
		apb(1'b1, tst_pkg::REG_BUF0, word0(f, tm), q, e);
		apb(1'b1, tst_pkg::REG_BUF1, {tm.month, tm.day, tm.hour, tm.min}, q, e);
		apb(1'b1, tst_pkg::REG_BUF2, {24'h000000, tm.year}, q, e);
		job(1'b1, num, len, s);
	endtask

	// valid bcd time; days stop at 28 so every month accepts them
	task rnd_time(output tst_pkg::tst_time_s tm);
		tm.frac = bcd(int'({$random(seed)} % 100));
		tm.sec = bcd(int'({$random(seed)} % 60));
		tm.min = bcd(int'({$random(seed)} % 60));
		tm.hour = bcd(int'({$random(seed)} % 24));
		tm.day = bcd(int'({$random(seed)} % 28 + 1));
		tm.month = bcd(int'({$random(seed)} % 12 + 1));
		tm.year = bcd(int'({$random(seed)} % 100));
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		seed = 32'h8d26;
		n_fail = 0;
		n_checks = 0;
		i_rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		// a follower after restart refuses a read
		chk_word({31'h0, dev_leader}, 32'h0);
		job(1'b0, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, st);
		chk_word(st & 32'h7, 32'h6);
		// flag-only send makes it leader
		load(1'b1, tst_pkg::JOB_TIME, tst_pkg::LEN_FLAG, '0, st);
		chk_word(st & 32'h7, 32'h2);
		chk_word({31'h0, dev_leader}, 32'h1);
		// sync call must not touch the flag
		apb(1'b1, tst_pkg::REG_CTRL, 32'h4, q, e);
		repeat (4) @(posedge i_clk);
		chk_word({31'h0, dev_leader}, 32'h1);
		// random loads, each read back in full
		repeat (6)
		begin
			rnd_time(t);
			load(1'b1, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, t, st);
			chk_time(dev_time, t);
			job(1'b0, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, st);
			chk_word(st & 32'hf, 32'ha);
			apb(1'b0, tst_pkg::REG_BUF0, 32'h0, q, e);
			chk_word(q & 32'hffff00ff, word0(1'b1, t));
			apb(1'b0, tst_pkg::REG_BUF1, 32'h0, q, e);
			chk_word(q, {t.month, t.day, t.hour, t.min});
			apb(1'b0, tst_pkg::REG_BUF2, 32'h0, q, e);
			chk_word(q, {24'h000000, t.year});
		end
		// foreign job numbers change nothing
		job(1'b0, 8'hdb, tst_pkg::LEN_FULL, st);
		chk_word(st & 32'h6, 32'h6);
		rnd_time(t2);
		load(1'b0, 8'h5a, tst_pkg::LEN_FULL, t2, st);
		chk_word(st & 32'h6, 32'h6);
		// a length other than one or ten is refused and changes nothing
		load(1'b0, tst_pkg::JOB_TIME, 4'h5, t2, st);
		chk_word(st & 32'h6, 32'h6);
		chk_time(dev_time, t);
		chk_word({31'h0, dev_leader}, 32'h1);
		// a time load without the flag demotes the device
		load(1'b0, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, t2, st);
		chk_word({31'h0, dev_leader}, 32'h0);
		job(1'b0, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, st);
		chk_word(st & 32'h6, 32'h6);
		// calendar corners, one hundredth past each
		for (int i = 0; i < 4; i++)
		begin
			load(1'b1, tst_pkg::JOB_TIME, tst_pkg::LEN_FULL, cin[i], st);
			k = 0;
			while (dev_time === cin[i] && k < 3000)
			begin
				@(posedge i_clk);
				k++;
			end
			chk_time(dev_time, cout[i]);
		end
		// unmapped register address
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk_word({31'h0, e}, 32'h1);
		end_sim;
	end
endmodule
